/* File: pkg/acc_consts.vh */
// register map, field positions, reset values and counts for the converter control block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ACC_ADDR_SC1 12'h000
`define ACC_ADDR_SC2 12'h004
`define ACC_ADDR_RH 12'h008
`define ACC_ADDR_RL 12'h00c
`define ACC_ADDR_CVH 12'h010
`define ACC_ADDR_CVL 12'h014
`define ACC_ADDR_CFG 12'h018
`define ACC_ADDR_W 12

// ------------------------------------------------------------
// status/control one fields
// ------------------------------------------------------------
`define ACC_SC1_DONE 7
`define ACC_SC1_AIEN 6
`define ACC_SC1_CONT 5
`define ACC_CH_OFF 5'h1f
`define ACC_SC1_RESET 8'h1f

// ------------------------------------------------------------
// status/control two fields
// ------------------------------------------------------------
`define ACC_SC2_ACT 7
`define ACC_SC2_TRG 6
`define ACC_SC2_CFE 5
`define ACC_SC2_CGT 4
`define ACC_SC2_RESET 8'h00

// ------------------------------------------------------------
// configuration fields
// ------------------------------------------------------------
`define ACC_CFG_LPC 7
`define ACC_CFG_DIV_HI 6
`define ACC_CFG_DIV_LO 5
`define ACC_CFG_LSMP 4
`define ACC_CFG_MODE_HI 3
`define ACC_CFG_MODE_LO 2
`define ACC_CFG_CLK_HI 1
`define ACC_CFG_CLK_LO 0
`define ACC_CFG_RESET 8'h00

// ------------------------------------------------------------
// encodings
// ------------------------------------------------------------
`define ACC_MODE_8 2'h0
`define ACC_MODE_12 2'h1
`define ACC_MODE_10 2'h2
`define ACC_ICLK_BUS 2'h0
`define ACC_ICLK_BUS2 2'h1
`define ACC_ICLK_ALT 2'h2
`define ACC_ICLK_ASYNC 2'h3

// ------------------------------------------------------------
// internal asynchronous clock: one tick per this many bus cycles
// ------------------------------------------------------------
`define ACC_ASYNC_DIV 4'h5

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

/* File: rtl/acc_adc_ctrl.v */
// converter control: registers, triggers, clock divide, rounding, compare and result interlock
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "acc_consts.vh"

// Notes on behaviour
// - active flag set on start, cleared end/abort
// - trigger select: software write or hardware input
// - compare enable bit turns compare on
// - bit four picks less-than or greater-equal
// - high result bits cleared per resolution mode
// - results kept when compare condition fails
// - compare hit stores result minus compare value
// - high read locks results until low read
// - eight-bit mode has no read interlock
// - low result holds low eight bits
// - high compare bits used per mode
// - low compare bits always compared
// - configuration bit seven selects low power
// - divider of one, two, four, eight
// - bit four selects long sample time
// - mode field picks 8, 12, 10 bits
// - input clock from four sources
// - complete flag set per compare, cleared by access
// - control one write aborts, then maybe starts
// - results rounded to 10 or 8 bits
module acc_adc_ctrl (
  input wire clk_i,
  input wire arst_n_i,
  // axi4-lite slave
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // pins
  input wire hw_trigger_input_i,
  input wire alternate_clock_i,
  // analog converter side, same clock domain
  input wire conv_done_i,
  input wire [11:0] conv_data_i,
  output reg conv_start_o,
  output reg conv_abort_o,
  output reg converter_clock_en_o,
  output reg [4:0] channel_select_o,
  output reg low_power_config_o,
  output reg long_sample_select_o,
  output reg [1:0] mode_o
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  reg [7:0] sc1_reg; // complete, irq enable, continuous, channel
  reg [7:0] sc2_reg; // register image: trigger, compare enable, ge select; active kept apart
  reg active_reg; // conversion in progress
  reg [7:0] cvh_reg; // compare high
  reg [7:0] cvl_reg; // compare low
  reg [7:0] cfg_reg; // configuration
  reg [7:0] rh_reg; // result high
  reg [7:0] rl_reg; // result low
  reg lock_reg; // high read seen, waiting for low read

  // ------------------------------------------------------------
  // bus slave state
  // ------------------------------------------------------------
  reg aw_held_reg; // write address taken
  reg w_held_reg; // write data taken
  reg [11:0] waddr_reg;
  reg [7:0] wdata_reg;
  reg wlane_reg; // low byte lane enabled

  // ------------------------------------------------------------
  // synchronisers and dividers
  // ------------------------------------------------------------
  reg hwt_meta_reg;
  reg hwt_sync_reg;
  reg hwt_prev_reg;
  reg alt_meta_reg;
  reg alt_sync_reg;
  reg alt_prev_reg;
  reg half_reg; // bus clock divided by two
  reg [3:0] ack_cnt_reg; // internal async clock stand-in
  reg [2:0] div_cnt_reg; // ratio counter

  // ------------------------------------------------------------
  // decoded fields
  // ------------------------------------------------------------
  wire [1:0] mode = cfg_reg[`ACC_CFG_MODE_HI:`ACC_CFG_MODE_LO];
  wire [1:0] iclk = cfg_reg[`ACC_CFG_CLK_HI:`ACC_CFG_CLK_LO];
  wire [1:0] div_sel = cfg_reg[`ACC_CFG_DIV_HI:`ACC_CFG_DIV_LO];
  wire hw_trig_sel = sc2_reg[`ACC_SC2_TRG];
  wire cmp_en = sc2_reg[`ACC_SC2_CFE];
  wire cmp_ge = sc2_reg[`ACC_SC2_CGT];
  wire ch_off = (sc1_reg[4:0] == `ACC_CH_OFF);
  wire is_8bit = (mode == `ACC_MODE_8);

  // ------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------
  wire aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  wire w_hs = s_axi_wvalid_i & s_axi_wready_o;
  wire ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  // write fires in the cycle both halves are held, while no response is pending
  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
  wire wr_map = (waddr_reg[1:0] == 2'h0) & (waddr_reg <= `ACC_ADDR_CFG); // seven aligned words
  wire wr_ok = wr_fire & wlane_reg;
  wire sc1_wr = wr_ok & (waddr_reg == `ACC_ADDR_SC1);
  wire rh_rd = ar_hs & (s_axi_araddr_i == `ACC_ADDR_RH);
  wire rl_rd = ar_hs & (s_axi_araddr_i == `ACC_ADDR_RL);

  // ------------------------------------------------------------
  // rounding and compare datapath
  // ------------------------------------------------------------
  reg [10:0] sum10; // raw rounded to ten bits, with carry
  reg [8:0] sum8; // raw rounded to eight bits, with carry
  reg [11:0] res; // rounded result, zero above N
  reg [11:0] cv; // compare value, zero above N
  reg [11:0] diff; // result minus compare value
  reg [11:0] stored; // value written on update
  reg cond; // compare condition true

  // round, mask and compare according to mode
  always @*
  begin
    sum10 = {1'b0, conv_data_i[11:2]} + {10'h000, conv_data_i[1]};
    sum8 = {1'b0, conv_data_i[11:4]} + {8'h00, conv_data_i[3]};
    case (mode)
      `ACC_MODE_8:
      begin
        // saturate so a full-scale round does not wrap to zero
        res = {4'h0, sum8[8] ? 8'hff : sum8[7:0]};
        cv = {4'h0, cvl_reg};
      end
      `ACC_MODE_10:
      begin
        res = {2'h0, sum10[10] ? 10'h3ff : sum10[9:0]};
        cv = {2'h0, cvh_reg[1:0], cvl_reg};
      end
      default:
      begin
        // twelve bit, reserved code behaves the same
        res = conv_data_i;
        cv = {cvh_reg[3:0], cvl_reg};
      end
    endcase
    diff = res - cv;
    if (is_8bit)
      diff = {4'h0, diff[7:0]};
    else if (mode == `ACC_MODE_10)
      diff = {2'h0, diff[9:0]};
    cond = cmp_ge ? (res >= cv) : (res < cv);
    stored = cmp_en ? diff : res;
  end

  // completion that passes compare (or compare off)
  wire done = conv_done_i & active_reg;
  wire cmp_pass = ~cmp_en | cond;
  // interlock only outside eight-bit mode
  wire blocked = lock_reg & ~is_8bit;
  wire upd = done & cmp_pass & ~blocked;

  // hardware trigger rising edge after synchroniser
  wire hwt_edge = hwt_sync_reg & ~hwt_prev_reg;
  wire hw_start = hw_trig_sel & hwt_edge & ~active_reg & ~ch_off;
  wire sw_start = sc1_wr & ~hw_trig_sel & (wdata_reg[4:0] != `ACC_CH_OFF);
  // continuous mode re-arms on completion
  wire cont_start = done & sc1_reg[`ACC_SC1_CONT] & ~ch_off;

  // ------------------------------------------------------------
  // converter clock source pick and divide
  // ------------------------------------------------------------
  reg src_tick;
  always @*
  begin
    case (iclk)
      `ACC_ICLK_BUS: src_tick = 1'b1;
      `ACC_ICLK_BUS2: src_tick = half_reg;
      `ACC_ICLK_ALT: src_tick = alt_sync_reg & ~alt_prev_reg;
      default: src_tick = (ack_cnt_reg == 4'h0);
    endcase
  end
  // ratio mask: 0, 1, 3, 7 for divide by 1, 2, 4, 8
  wire [2:0] div_mask = (3'h1 << div_sel) - 3'h1;
  wire ck_tick = src_tick & ((div_cnt_reg & div_mask) == div_mask);

  // ------------------------------------------------------------
  // synchronisers and divider counters
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hwt_meta_reg <= 1'b0;
      hwt_sync_reg <= 1'b0;
      hwt_prev_reg <= 1'b0;
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
      alt_prev_reg <= 1'b0;
      half_reg <= 1'b0;
      ack_cnt_reg <= 4'h0;
      div_cnt_reg <= 3'h0;
      converter_clock_en_o <= 1'b0;
    end
    else
    begin
      // pins pass two flops before any logic
      hwt_meta_reg <= hw_trigger_input_i;
      hwt_sync_reg <= hwt_meta_reg;
      hwt_prev_reg <= hwt_sync_reg;
      alt_meta_reg <= alternate_clock_i;
      alt_sync_reg <= alt_meta_reg;
      alt_prev_reg <= alt_sync_reg;
      half_reg <= ~half_reg;
      // async clock modelled as a free bus-clock divider
      ack_cnt_reg <= (ack_cnt_reg == `ACC_ASYNC_DIV - 4'h1) ? 4'h0 : ack_cnt_reg + 4'h1;
      if (src_tick)
        div_cnt_reg <= div_cnt_reg + 3'h1;
      converter_clock_en_o <= ck_tick;
    end
  end

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `ACC_RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end
    else
    begin
      // address and data are taken in either order
      if (aw_hs)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_hs)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i[7:0];
        wlane_reg <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
      // re-open both channels only after the response is taken
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi read channel, side effects at address acceptance
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `ACC_RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `ACC_RESP_OKAY;
        case (s_axi_araddr_i)
          `ACC_ADDR_SC1: s_axi_rdata_o <= {24'h00_0000, sc1_reg};
          `ACC_ADDR_SC2: s_axi_rdata_o <= {24'h00_0000, active_reg, sc2_reg[6:0]};
          // upper result bits read as zero for the current mode, stale or not
          `ACC_ADDR_RH: s_axi_rdata_o <= {24'h00_0000, 4'h0, rh_reg[3:2] & {2{mode[0]}}, rh_reg[1:0] & {2{~is_8bit}}};
          `ACC_ADDR_RL: s_axi_rdata_o <= {24'h00_0000, rl_reg};
          `ACC_ADDR_CVH: s_axi_rdata_o <= {24'h00_0000, cvh_reg};
          `ACC_ADDR_CVL: s_axi_rdata_o <= {24'h00_0000, cvl_reg};
          `ACC_ADDR_CFG: s_axi_rdata_o <= {24'h00_0000, cfg_reg};
          default:
          begin
            // unmapped: zero data, slave error
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `ACC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // control registers, conversion sequencing and results
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sc1_reg <= `ACC_SC1_RESET;
      sc2_reg <= `ACC_SC2_RESET;
      active_reg <= 1'b0;
      cvh_reg <= 8'h00;
      cvl_reg <= 8'h00;
      cfg_reg <= `ACC_CFG_RESET;
      rh_reg <= 8'h00;
      rl_reg <= 8'h00;
      lock_reg <= 1'b0;
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
      channel_select_o <= `ACC_CH_OFF;
      low_power_config_o <= 1'b0;
      long_sample_select_o <= 1'b0;
      mode_o <= `ACC_MODE_8;
    end
    else
    begin
      conv_start_o <= sw_start | (~sc1_wr & (hw_start | cont_start));
      conv_abort_o <= sc1_wr & active_reg;
      channel_select_o <= sc1_reg[4:0]; // analog-side copies lag one cycle
      low_power_config_o <= cfg_reg[`ACC_CFG_LPC];
      long_sample_select_o <= cfg_reg[`ACC_CFG_LSMP];
      mode_o <= mode;
      // plain writable registers; results, active flag are read-only
      if (wr_ok && waddr_reg == `ACC_ADDR_SC2)
        sc2_reg <= {1'b0, wdata_reg[`ACC_SC2_TRG:`ACC_SC2_CGT], 4'h0};
      if (wr_ok && waddr_reg == `ACC_ADDR_CVH)
        cvh_reg <= wdata_reg;
      if (wr_ok && waddr_reg == `ACC_ADDR_CVL)
        cvl_reg <= wdata_reg;
      // mode changes leave stale results for software to ignore
      if (wr_ok && waddr_reg == `ACC_ADDR_CFG)
        cfg_reg <= wdata_reg;
      // control one write: new fields, complete flag cleared
      if (sc1_wr)
        sc1_reg <= {1'b0, wdata_reg[6:0]};
      else if (rl_rd)
        sc1_reg[`ACC_SC1_DONE] <= 1'b0;
      // completion set wins over either clear
      if (done && cmp_pass)
        sc1_reg[`ACC_SC1_DONE] <= 1'b1;
      // active flag: abort and restart on control one write
      if (sc1_wr)
        active_reg <= sw_start;
      else if (done)
        active_reg <= cont_start;
      else if (hw_start)
        active_reg <= 1'b1;
      // result transfer
      if (upd)
      begin
        rh_reg <= {4'h0, stored[11:8]};
        rl_reg <= stored[7:0];
      end
      // interlock: low read releases, later high read re-arms
      if (rl_rd)
        lock_reg <= 1'b0;
      else if (rh_rd && !is_8bit)
        lock_reg <= 1'b1;
    end
  end

endmodule

/* File: test/acc_adc_ctrl_chk.sv */
// bus timing and result-format assertions for the converter control block
`timescale 1ns/1ps
`include "acc_consts.vh"
module acc_adc_ctrl_chk (
  input wire clk_i,
  input wire arst_n_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire conv_start_o,
  input wire [1:0] mode_o
);
  // ----------------------------------------
  // address of the read in flight
  // ----------------------------------------
  reg [11:0] rd_addr_reg;
  // captured at the address handshake, so it lines up with rvalid
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_addr_reg <= 12'h000;
    else if (s_axi_arvalid_i && s_axi_arready_o)
      rd_addr_reg <= s_axi_araddr_i;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data not offered one cycle after address");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped or changed before taken");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped before taken");
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o)
    else $error("write response not two cycles after handshake");
  aw_block_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o [*2])
    else $error("second write address taken too early");
  upper_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  unmapped_err_a: assert property (s_axi_rvalid_o && rd_addr_reg > `ACC_ADDR_CFG
    |-> s_axi_rresp_o == `ACC_RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  high_ten_a: assert property (s_axi_rvalid_o && rd_addr_reg == `ACC_ADDR_RH && mode_o == `ACC_MODE_10
    |-> s_axi_rdata_o[7:2] == 6'h00)
    else $error("result high upper bits set in ten-bit mode");
  high_eight_a: assert property (s_axi_rvalid_o && rd_addr_reg == `ACC_ADDR_RH && mode_o == `ACC_MODE_8
    |-> s_axi_rdata_o[7:0] == 8'h00)
    else $error("result high not clear in eight-bit mode");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
endmodule
bind acc_adc_ctrl acc_adc_ctrl_chk u_acc_adc_ctrl_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .conv_start_o(conv_start_o), .mode_o(mode_o)
);

/* File: test/test_acc_adc_ctrl.sv */
// register-level bench for the converter control block
`timescale 1ns/1ps
`include "acc_consts.vh"
module test_acc_adc_ctrl;
  // ----------------------------------------
  // stimulus, outputs and counters
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, conv_data = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic [3:0] wstrb = 4'h0;
  // responses are always accepted at once
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic hw_trig = 1'b0, alt_clk = 1'b0, conv_done = 1'b0;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, start, abort, clk_en, lpc, lsmp;
  wire [1:0] bresp, rresp, mode;
  wire [31:0] rdata;
  wire [4:0] chan;
  int failures = 0, compares = 0, cycles = 0, n_start = 0, n_abort = 0, n_en = 0, e;

  acc_adc_ctrl u_acc_adc_ctrl (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .hw_trigger_input_i(hw_trig), .alternate_clock_i(alt_clk),
    .conv_done_i(conv_done), .conv_data_i(conv_data), .conv_start_o(start), .conv_abort_o(abort),
    .converter_clock_en_o(clk_en), .channel_select_o(chan), .low_power_config_o(lpc),
    .long_sample_select_o(lsmp), .mode_o(mode)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `ACC_RESP_OKAY);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge clk_i);
      if (awready === 1'b1 && !aw_d)
      begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_d)
      begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk_i);
    check($sformatf("write response at %h", a), bresp, er);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] x, input logic [1:0] er = `ACC_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge clk_i);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    do
      @(posedge clk_i);
    while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    check($sformatf("data at %h", a), rd, {24'h00_0000, x});
    check($sformatf("read response at %h", a), rs, er);
  endtask

  // one-cycle completion from the converter
  task automatic conv(input logic [11:0] raw);
    conv_data <= raw;
    conv_done <= 1'b1;
    @(posedge clk_i);
    conv_done <= 1'b0;
    repeat (3)
      @(posedge clk_i);
  endtask

  // set up, start, complete, then read flag and both results
  task automatic cv(input logic [7:0] sc2, cfg, input logic [11:0] raw, input logic [7:0] cc, rh, rl);
    wr(`ACC_ADDR_SC2, sc2);
    wr(`ACC_ADDR_CFG, cfg);
    wr(`ACC_ADDR_SC1, 8'h03);
    check("mode", mode, cfg[3:2]);
    conv(raw);
    rchk(`ACC_ADDR_SC1, cc);
    rchk(`ACC_ADDR_RH, rh);
    rchk(`ACC_ADDR_RL, rl);
  endtask

  // ----------------------------------------
  // clock, alternate clock, counters, hang guard
  // ----------------------------------------
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // alternate clock has a period of four bus cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    alt_clk <= cycles[1];
    n_start <= n_start + (start === 1'b1);
    n_abort <= n_abort + (abort === 1'b1);
    n_en <= n_en + (clk_en === 1'b1);
    if (cycles == 20000)
    begin
      failures = failures + 1;
      end_of_test;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10)
      @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++)
      rchk(12'(i * 4), i == 0 ? `ACC_SC1_RESET : 8'h00);
    wr(12'h01c, 8'h5a, `ACC_RESP_SLVERR);
    rchk(12'h01c, 8'h00, `ACC_RESP_SLVERR);
    wr(`ACC_ADDR_RH, 8'hff);
    rchk(`ACC_ADDR_RH, 8'h00);
    wr(`ACC_ADDR_CVL, 8'ha5);
    rchk(`ACC_ADDR_CVL, 8'ha5);
    // every source and divide; window is a multiple of each tick period
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 4; d++)
      begin
        wr(`ACC_ADDR_CFG, {1'b1, d[1:0], 1'b1, 2'h1, s[1:0]});
        repeat (40)
          @(posedge clk_i);
        e = n_en;
        repeat (160)
          @(posedge clk_i);
        check("converter ticks", n_en - e, 160 / ((s == 3 ? 5 : 1 << s) << d));
      end
    check("low power", lpc, 1'b1);
    check("long sample", lsmp, 1'b1);
    rchk(`ACC_ADDR_CFG, 8'hf7);
    // software start and plain twelve-bit result
    wr(`ACC_ADDR_CFG, 8'h04);
    e = n_start;
    wr(`ACC_ADDR_SC1, 8'h03);
    rchk(`ACC_ADDR_SC2, 8'h80);
    check("starts", n_start - e, 1);
    check("channel", chan, 5'h03);
    check("low power off", lpc, 1'b0);
    conv(12'habc);
    rchk(`ACC_ADDR_SC2, 8'h00);
    rchk(`ACC_ADDR_SC1, 8'h83);
    rchk(`ACC_ADDR_RH, 8'h0a);
    rchk(`ACC_ADDR_RL, 8'hbc);
    rchk(`ACC_ADDR_SC1, 8'h03);
    // rounding with saturation, then compare in both senses
    cv(8'h00, 8'h08, 12'h3fe, 8'h83, 8'h01, 8'h00);
    cv(8'h00, 8'h08, 12'hffe, 8'h83, 8'h03, 8'hff);
    cv(8'h00, 8'h00, 12'hff8, 8'h83, 8'h00, 8'hff);
    cv(8'h00, 8'h00, 12'h0a8, 8'h83, 8'h00, 8'h0b);
    wr(`ACC_ADDR_CVH, 8'h01);
    wr(`ACC_ADDR_CVL, 8'h00);
    cv(8'h30, 8'h04, 12'h180, 8'h83, 8'h00, 8'h80);
    cv(8'h30, 8'h04, 12'h0f0, 8'h03, 8'h00, 8'h80);
    cv(8'h20, 8'h04, 12'h0f0, 8'h83, 8'h0f, 8'hf0);
    cv(8'h20, 8'h04, 12'h180, 8'h03, 8'h0f, 8'hf0);
    wr(`ACC_ADDR_CVH, 8'h0f);
    wr(`ACC_ADDR_CVL, 8'h10);
    cv(8'h30, 8'h00, 12'h200, 8'h83, 8'h00, 8'h10);
    cv(8'h30, 8'h08, 12'hc44, 8'h83, 8'h00, 8'h01);
    cv(8'h10, 8'h04, 12'hf20, 8'h83, 8'h0f, 8'h20);
    // high read locks out the next result until low is read
    wr(`ACC_ADDR_SC1, 8'h03);
    conv(12'h123);
    rchk(`ACC_ADDR_RH, 8'h01);
    wr(`ACC_ADDR_SC1, 8'h03);
    conv(12'h456);
    rchk(`ACC_ADDR_RL, 8'h23);
    wr(`ACC_ADDR_SC1, 8'h03);
    conv(12'h789);
    rchk(`ACC_ADDR_RL, 8'h89);
    // no lock in eight-bit mode
    wr(`ACC_ADDR_CFG, 8'h00);
    wr(`ACC_ADDR_SC1, 8'h03);
    conv(12'h120);
    rchk(`ACC_ADDR_RH, 8'h00);
    wr(`ACC_ADDR_SC1, 8'h03);
    conv(12'h340);
    rchk(`ACC_ADDR_RL, 8'h34);
    // hardware trigger: write does not start, one pin rise starts once
    wr(`ACC_ADDR_SC2, 8'h40);
    e = n_start;
    wr(`ACC_ADDR_SC1, 8'h03);
    hw_trig <= 1'b1;
    repeat (12)
      @(posedge clk_i);
    hw_trig <= 1'b0;
    rchk(`ACC_ADDR_SC2, 8'hc0);
    check("trigger starts", n_start - e, 1);
    conv(12'h550);
    rchk(`ACC_ADDR_RL, 8'h55);
    // abort by a channel-off write in mid-conversion
    wr(`ACC_ADDR_SC2, 8'h00);
    wr(`ACC_ADDR_SC1, 8'h03);
    e = n_abort;
    wr(`ACC_ADDR_SC1, `ACC_SC1_RESET);
    rchk(`ACC_ADDR_SC2, 8'h00);
    check("aborts", n_abort - e, 1);
    // continuous bit: completion restarts and keeps the active flag
    e = n_start;
    wr(`ACC_ADDR_SC1, 8'h23);
    conv(12'h000);
    rchk(`ACC_ADDR_SC2, 8'h80);
    check("restarts", n_start - e, 2);
    wr(`ACC_ADDR_SC1, `ACC_SC1_RESET);
    end_of_test;
  end
endmodule
